// file: sim/pbcl_host_model.sv
`timescale 1ns/1ps
module pbcl_host_model (
  input  wire logic       status_line_in,
  output logic            request_n_out,
  output logic            cfg_clk_out,
  output logic [7:0]      cfg_data_out,
  output logic            user_clk_out
);
  // The link clock stands low between bytes, so pauses cost nothing.
  initial begin
    request_n_out = 1'h0;
    cfg_clk_out = 1'h0;
    cfg_data_out = 8'h00;
    user_clk_out = 1'h0;
  end
  task automatic set_request(input logic v);
    request_n_out <= v;
  endtask
  task automatic wait_status(output logic ok);
    ok = 1'h0;
    for (int n = 0; n < 400 && !ok; n++) begin
      #10;
      ok = (status_line_in === 1'h1);
    end
  endtask
  // Quad mode runs three spare rises after each capture.
  task automatic send_byte(input logic [7:0] b, input logic quad);
    cfg_data_out <= b;
    #20;
    repeat (quad ? 4 : 1) begin
      cfg_clk_out <= 1'h1;
      #62.5;
      cfg_clk_out <= 1'h0;
      #62.5;
    end
  endtask
  task automatic idle();
    cfg_data_out <= 8'h00;
    cfg_clk_out <= 1'h0;
  endtask
  task automatic user_clocks(input int n);
    repeat (n) begin
      user_clk_out <= 1'h1;
      #62.5;
      user_clk_out <= 1'h0;
      #62.5;
    end
  endtask
endmodule

// file: sim/pbcl_loader_assertions.sv
`timescale 1ns/1ps
module pbcl_chk #(
  parameter int ERR_TIMEOUT_CYC = 10000
) (
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        config_request_line_n_in,
  input wire logic        config_status_line_in,
  input wire logic        config_status_line_oe_out,
  input wire logic        load_complete_flag_in,
  input wire logic        load_complete_flag_oe_out,
  input wire logic        startup_complete_oe_out,
  input wire logic        config_data_oe_out,
  input wire logic        chain_enable_n_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  a_ack_answer:
    assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("bus request not answered");
  a_ack_pulse:
    assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_dat_idle:
    assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack");
  a_status_release:
    assert property ($rose(config_request_line_n_in) |->
      ##[1:8] !config_status_line_oe_out)
    else $error("status not released after request high");
  a_req_low_hold:
    assert property ($fell(config_request_line_n_in) |->
      ##[1:6] (config_status_line_oe_out && load_complete_flag_oe_out))
    else $error("request low did not pull status and load");
  a_pins_off_cfg:
    assert property ((!config_request_line_n_in)[*6] |-> !config_data_oe_out)
    else $error("byte pins driven while request low");
  a_pins_user:
    assert property (config_data_oe_out |->
      !config_status_line_oe_out && !load_complete_flag_oe_out)
    else $error("byte pins driven outside user mode");
  a_chain_order:
    assert property ($fell(chain_enable_n_out) |-> !load_complete_flag_oe_out)
    else $error("chain out before load release");
  a_startup_rel:
    assert property ($fell(startup_complete_oe_out) &&
      config_request_line_n_in && config_status_line_in |->
      load_complete_flag_in)
    else $error("startup released before load line high");
endmodule

bind pbcl_loader pbcl_chk #(.ERR_TIMEOUT_CYC(ERR_TIMEOUT_CYC)) pbcl_chk_inst (
  .clk_sys_in, .sys_rst_in, .wb_cyc_in, .wb_stb_in, .wb_dat_out, .wb_ack_out,
  .config_request_line_n_in, .config_status_line_in,
  .config_status_line_oe_out, .load_complete_flag_in,
  .load_complete_flag_oe_out, .startup_complete_oe_out,
  .config_data_oe_out, .chain_enable_n_out);

// file: sim/pbcl_loader_tb_top.sv
`timescale 1ns/1ps
`include "pbcl_regs.svh"
module pbcl_loader_tb_top;
  logic        clk_sys_in, sys_rst_in, cyc, stb, we, ack, req_n, cfg_clk;
  logic        usr_clk, chain_n_in, status_oe, load_oe, start_oe, data_oe;
  logic        chain_n_out, ok;
  logic [3:0]  adr, sel;
  logic [7:0]  cfg_data, data_out;
  logic [31:0] wdat, rdat, q;
  int          errors, cmp_count, cycles;

  pbcl_loader #(.ERR_TIMEOUT_CYC(200)) pbcl_loader_inst (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .config_request_line_n_in(req_n), .config_status_line_in(~status_oe),
    .config_status_line_oe_out(status_oe), .load_complete_flag_in(~load_oe),
    .load_complete_flag_oe_out(load_oe), .startup_complete_oe_out(start_oe),
    .configuration_clock_in(cfg_clk), .user_startup_clock_in(usr_clk),
    .config_data_in(cfg_data), .config_data_out(data_out),
    .config_data_oe_out(data_oe), .chain_enable_n_in(chain_n_in),
    .chain_enable_n_out(chain_n_out));
  pbcl_host_model host (.status_line_in(~status_oe), .request_n_out(req_n),
    .cfg_clk_out(cfg_clk), .cfg_data_out(cfg_data), .user_clk_out(usr_clk));

  initial begin
    clk_sys_in = 1'h0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors = errors + 1;
      close_out();
    end
  end
  task automatic close_out();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // The master waits on ack with its own bound, never a fixed latency.
  task automatic wb_rw(input logic w, input logic [3:0] a, input [31:0] d);
    int n;
    @(posedge clk_sys_in);
    {cyc, stb, we, adr, wdat} <= {1'h1, 1'h1, w, a, d};
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (ack !== 1'h1 && n < 20);
    q = rdat;
    {cyc, stb} <= 2'h0;
    if (n >= 20) chk("ack", 32'h1, 32'h0);
  endtask
  task automatic reg_chk(input string n, input logic [3:0] a, input [31:0] e);
    wb_rw(1'h0, a, 32'h0);
    chk(n, e, q);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic stream(input logic quad, input logic [7:0] opt);
    logic [7:0] b [4] = '{8'hA5, opt, 8'h33, 8'h44};
    for (int i = 0; i < 4; i++) begin
      if (i == 2) #5000;
      host.send_byte(b[i], quad);
      settle(6);
      chk("load_oe", 32'(i < 2), 32'(load_oe));
      chk("chain_out", 32'(i != 3), 32'(chain_n_out));
      chk("startup_oe", 32'(i > 0 && opt[0]), 32'(start_oe));
    end
    host.idle();
  endtask

  initial begin
    {sys_rst_in, cyc, stb, we, adr, wdat, chain_n_in} = {3'h4, 38'h0};
    {errors, cmp_count, cycles} = 0;
    sel = 4'hF;
    repeat (6) @(posedge clk_sys_in);
    sys_rst_in <= 1'h0;
    settle(1);
    chk("reset_pins", 32'h1A,
        32'({status_oe, load_oe, start_oe, chain_n_out, data_oe}));
    reg_chk("ctrl", `PBCL_ADR_CTRL, 32'h0);
    reg_chk("len", `PBCL_ADR_LEN, 32'h100);
    reg_chk("uio", `PBCL_ADR_UIO, 32'h0);
    wb_rw(1'h1, 4'h2, 32'hFFFF_FFFF);
    reg_chk("unmapped", 4'h2, 32'h0);
    sel <= 4'h1;
    wb_rw(1'h1, `PBCL_ADR_LEN, 32'hFF04);
    reg_chk("len_lane", `PBCL_ADR_LEN, 32'h104);
    sel <= 4'hF;
    wb_rw(1'h1, `PBCL_ADR_LEN, 32'h4);
    wb_rw(1'h1, `PBCL_ADR_CTRL, 32'hA);
    wb_rw(1'h1, `PBCL_ADR_UIO, 32'h5A);
    reg_chk("len", `PBCL_ADR_LEN, 32'h4);
    host.set_request(1'h1);
    host.wait_status(ok);
    chk("status_up", 32'h1, 32'(ok));
    host.user_clocks(10);
    @(posedge clk_sys_in) chain_n_in <= 1'h1;
    settle(4);
    host.send_byte(8'h3C, 1'h0);
    settle(6);
    chk("chain_off", 32'h0, 32'(status_oe));
    @(posedge clk_sys_in) chain_n_in <= 1'h0;
    settle(4);
    stream(1'h0, 8'h01);
    host.user_clocks(298);
    settle(8);
    chk("startup_early", 32'h1, 32'(start_oe));
    host.user_clocks(1);
    settle(8);
    chk("startup_done", 32'h0, 32'(start_oe));
    chk("pins_user", 32'h15A, 32'({data_oe, data_out}));
    wb_rw(1'h0, `PBCL_ADR_STAT, 32'h0);
    chk("state_user", 32'h7, 32'(q[18:16]));
    host.set_request(1'h0);
    settle(8);
    chk("req_low", 32'h6, 32'({status_oe, load_oe, data_oe}));
    wb_rw(1'h1, `PBCL_ADR_CTRL, 32'h5);
    settle(200);
    host.set_request(1'h1);
    host.wait_status(ok);
    host.send_byte(8'h3C, 1'h1);
    settle(6);
    chk("error_status", 32'h1, 32'(status_oe));
    host.wait_status(ok);
    chk("auto_restart", 32'h1, 32'(ok));
    stream(1'h1, 8'h00);
    settle(2100);
    chk("no_startup", 32'h0, 32'(start_oe));
    wb_rw(1'h0, `PBCL_ADR_STAT, 32'h0);
    chk("state_err", 32'hF, 32'({q[22], q[18:16]}));
    close_out();
  end
endmodule

// file: verilog/pbcl_loader.sv
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "pbcl_regs.svh"
module pbcl_loader #(
  parameter int ERR_TIMEOUT_CYC = `PBCL_ERR_TIMEOUT_CYC
) (
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        config_request_line_n_in,
  input  wire logic        config_status_line_in,
  output logic             config_status_line_oe_out,
  input  wire logic        load_complete_flag_in,
  output logic             load_complete_flag_oe_out,
  output logic             startup_complete_oe_out,
  input  wire logic        configuration_clock_in,
  input  wire logic        user_startup_clock_in,
  input  wire logic [7:0]  config_data_in,
  output logic      [7:0]  config_data_out,
  output logic             config_data_oe_out,
  input  wire logic        chain_enable_n_in,
  output logic             chain_enable_n_out
);
  localparam logic [13:0] ERR_LAST = 14'(ERR_TIMEOUT_CYC - 1);
  // Pin synchronisers: data is sampled in the same stages as its clock.
  logic [13:0] pins_sync;
  logic        req_s;
  logic        stat_s;
  logic        load_s;
  logic        configuration_clock_s;
  logic        uclk_s;
  logic        cen_n_s;
  logic [7:0]  data_s;
  pbcl_sync #(
    .WIDTH(14)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({config_request_line_n_in, config_status_line_in,
                  load_complete_flag_in, configuration_clock_in,
                  user_startup_clock_in, chain_enable_n_in,
                  config_data_in}),
    .sync_out   (pins_sync)
  );
  assign req_s   = pins_sync[13];
  assign stat_s  = pins_sync[12];
  assign load_s  = pins_sync[11];
  assign configuration_clock_s  = pins_sync[10];
  assign uclk_s  = pins_sync[9];
  assign cen_n_s = pins_sync[8];
  assign data_s  = pins_sync[7:0];
  // Software registers.
  logic [`PBCL_CTRL_W-1:0] ctrl;
  logic [`PBCL_LEN_W-1:0]  len;
  logic [7:0]              uio;
  logic [`PBCL_CTRL_W-1:0] next_ctrl;
  logic [`PBCL_LEN_W-1:0]  next_len;
  logic [7:0]              next_uio;
  logic [31:0]             next_wb_dat;
  logic                    next_wb_ack;
  logic [7:0]              next_data_out;
  logic                    next_data_oe;
  // Loader state.
  pbcl_pkg::pbcl_state_t   state;
  pbcl_pkg::pbcl_state_t   next_state;
  logic [`PBCL_LEN_W-1:0]  byte_cnt;
  logic [`PBCL_LEN_W-1:0]  next_byte_cnt;
  logic [1:0]              phase;
  logic [1:0]              next_phase;
  logic [13:0]             err_cnt;
  logic [13:0]             next_err_cnt;
  logic                    err_seen;
  logic                    next_err_seen;
  logic                    configuration_clock_d;
  logic                    uclk_d;
  logic                    next_stat_oe;
  logic                    next_load_oe;
  logic                    next_init_oe;
  logic                    next_cen_out_n;
  logic                    run_init;
  logic                    next_run_init;
  logic                    init_done;
  logic                    configuration_clock_rise;
  logic                    uclk_rise;
  logic                    take_byte;
  assign configuration_clock_rise = configuration_clock_s & ~configuration_clock_d;
  assign uclk_rise = uclk_s & ~uclk_d;
  // The chain enable gates capture, so a disabled device just watches.
  assign take_byte = configuration_clock_rise && !cen_n_s &&
                     (!ctrl[`PBCL_CTRL_QUAD] || phase == 2'h0);
  // The user clock drives the startup counter only when PBCL_CTRL_USERCLK is set, never the capture.
  pbcl_startup u_startup (
    .clk_sys_in       (clk_sys_in),
    .sys_rst_in       (sys_rst_in),
    .run_in           (run_init),
    .use_user_clk_in  (ctrl[`PBCL_CTRL_USERCLK]),
    .user_clk_rise_in (uclk_rise),
    .done_out         (init_done)
  );
  always_comb begin
    next_state     = state;
    next_byte_cnt  = byte_cnt;
    next_phase     = phase;
    next_err_cnt   = err_cnt;
    next_err_seen  = err_seen;
    next_stat_oe   = config_status_line_oe_out;
    next_load_oe   = load_complete_flag_oe_out;
    next_init_oe   = startup_complete_oe_out;
    next_cen_out_n = chain_enable_n_out;
    next_run_init  = 1'b0;
    case (state)
      pbcl_pkg::PBCL_ST_RESET: begin
        if (req_s) begin
          next_stat_oe = 1'b0;
          next_state   = pbcl_pkg::PBCL_ST_WAIT_STAT;
        end
      end
      pbcl_pkg::PBCL_ST_WAIT_STAT: begin
        next_stat_oe   = 1'b0;
        next_load_oe   = 1'b1;
        next_init_oe   = 1'b0;
        next_cen_out_n = 1'b1;
        next_byte_cnt  = '0;
        next_phase     = 2'h0;
        if (stat_s) begin
          next_state = pbcl_pkg::PBCL_ST_LOAD;
        end
      end
      pbcl_pkg::PBCL_ST_LOAD, pbcl_pkg::PBCL_ST_WAIT_DONE: begin
        if (!stat_s) begin
          // Another device flagged an error on the shared line.
          next_state = pbcl_pkg::PBCL_ST_WAIT_STAT;
        end else begin
          if (configuration_clock_rise && !cen_n_s && ctrl[`PBCL_CTRL_QUAD]) begin
            next_phase = phase + 2'h1;
          end
          if (take_byte && byte_cnt != len) begin
            next_byte_cnt = byte_cnt + 16'h0001;
            if (byte_cnt == 16'h0000 && data_s != `PBCL_SYNC_BYTE) begin
              next_stat_oe  = 1'b1;
              next_err_seen = 1'b1;
              next_err_cnt  = 14'h0000;
              next_state    = pbcl_pkg::PBCL_ST_ERROR;
            end else begin
              if (byte_cnt == 16'h0001 && data_s[`PBCL_OPT_INIT_BIT]) begin
                next_init_oe = 1'b1;
              end
              if (byte_cnt + 16'h0001 == len - 16'h0001) begin
                next_load_oe = 1'b0;
                next_state   = pbcl_pkg::PBCL_ST_WAIT_DONE;
              end
              if (byte_cnt + 16'h0001 == len) begin
                next_cen_out_n = 1'b0;
              end
            end
          end
          if (state == pbcl_pkg::PBCL_ST_WAIT_DONE && load_s &&
              byte_cnt == len) begin
            // Every device on the shared line starts together.
            next_run_init = 1'b1;
            next_state    = pbcl_pkg::PBCL_ST_INIT;
          end
        end
      end
      pbcl_pkg::PBCL_ST_INIT: begin
        next_run_init = 1'b1;
        if (!stat_s) begin
          next_run_init = 1'b0;
          next_state    = pbcl_pkg::PBCL_ST_WAIT_STAT;
        end else if (init_done) begin
          next_init_oe = 1'b0;
          next_state   = pbcl_pkg::PBCL_ST_USER;
        end
      end
      pbcl_pkg::PBCL_ST_USER: next_init_oe = 1'b0;
      pbcl_pkg::PBCL_ST_ERROR: begin
        next_stat_oe  = 1'b1;
        next_load_oe  = 1'b1;
        next_init_oe  = 1'b0;
        next_byte_cnt = '0;
        if (ctrl[`PBCL_CTRL_AUTORST]) begin
          next_err_cnt = err_cnt + 14'h0001;
          if (err_cnt == ERR_LAST) begin
            next_stat_oe = 1'b0;
            next_state   = pbcl_pkg::PBCL_ST_WAIT_STAT;
          end
        end
      end
      default: next_state = pbcl_pkg::PBCL_ST_RESET;
    endcase
    // A low request overrides everything and restarts the whole cycle.
    if (!req_s) begin
      next_state     = pbcl_pkg::PBCL_ST_RESET;
      next_stat_oe   = 1'b1;
      next_load_oe   = 1'b1;
      next_init_oe   = 1'b0;
      next_cen_out_n = 1'b1;
      next_run_init  = 1'b0;
      next_byte_cnt  = '0;
      next_phase     = 2'h0;
      next_err_cnt   = 14'h0000;
    end
  end
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state                     <= pbcl_pkg::PBCL_ST_RESET;
      byte_cnt                  <= '0;
      phase                     <= 2'h0;
      err_cnt                   <= 14'h0000;
      err_seen                  <= 1'b0;
      configuration_clock_d                    <= 1'b0;
      uclk_d                    <= 1'b0;
      config_status_line_oe_out <= 1'b1;
      load_complete_flag_oe_out <= 1'b1;
      startup_complete_oe_out   <= 1'b0;
      chain_enable_n_out        <= 1'b1;
      run_init                  <= 1'b0;
    end else begin
      state                     <= next_state;
      byte_cnt                  <= next_byte_cnt;
      phase                     <= next_phase;
      err_cnt                   <= next_err_cnt;
      err_seen                  <= next_err_seen;
      configuration_clock_d                    <= configuration_clock_s;
      uclk_d                    <= uclk_s;
      config_status_line_oe_out <= next_stat_oe;
      load_complete_flag_oe_out <= next_load_oe;
      startup_complete_oe_out   <= next_init_oe;
      chain_enable_n_out        <= next_cen_out_n;
      run_init                  <= next_run_init;
    end
  end
  // Wishbone slave: one wait state, unmapped reads return zero.
  always_comb begin
    next_ctrl     = ctrl;
    next_len      = len;
    next_uio      = uio;
    next_wb_dat   = 32'h0000_0000;
    next_wb_ack   = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    if (next_wb_ack && wb_we_in) begin
      case (wb_adr_in)
        `PBCL_ADR_CTRL: begin
          if (wb_sel_in[0]) begin
            next_ctrl = wb_dat_in[`PBCL_CTRL_W-1:0];
          end
        end
        `PBCL_ADR_LEN: begin
          if (wb_sel_in[0]) begin
            next_len[7:0] = wb_dat_in[7:0];
          end
          if (wb_sel_in[1]) begin
            next_len[15:8] = wb_dat_in[15:8];
          end
        end
        `PBCL_ADR_UIO: begin
          if (wb_sel_in[0]) begin
            next_uio = wb_dat_in[7:0];
          end
        end
        default: next_uio = uio;
      endcase
    end
    if (next_wb_ack && !wb_we_in) begin
      case (wb_adr_in)
        `PBCL_ADR_CTRL: next_wb_dat[`PBCL_CTRL_W-1:0] = ctrl;
        `PBCL_ADR_LEN:  next_wb_dat[15:0] = len;
        `PBCL_ADR_STAT: begin
          next_wb_dat[15:0]                   = byte_cnt;
          next_wb_dat[`PBCL_STAT_STATE_LSB+:3] = state;
          next_wb_dat[`PBCL_STAT_STATUS_LINE] = stat_s;
          next_wb_dat[`PBCL_STAT_LOAD_LINE]   = load_s;
          next_wb_dat[`PBCL_STAT_INIT_DRIVE]  = startup_complete_oe_out;
          next_wb_dat[`PBCL_STAT_ERROR]       = err_seen;
          next_wb_dat[`PBCL_STAT_CHAIN_OUT]   = chain_enable_n_out;
        end
        `PBCL_ADR_UIO:  next_wb_dat[7:0] = uio;
        default:        next_wb_dat = 32'h0000_0000;
      endcase
    end
    // Byte pins only drive in user mode when software claims them.
    next_data_out = uio;
    next_data_oe  = (state == pbcl_pkg::PBCL_ST_USER) && req_s &&
                    ctrl[`PBCL_CTRL_USERIO];
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl               <= `PBCL_CTRL_RST;
      len                <= `PBCL_LEN_RST;
      uio                <= `PBCL_UIO_RST;
      wb_dat_out         <= 32'h0000_0000;
      wb_ack_out         <= 1'b0;
      config_data_out    <= 8'h00;
      config_data_oe_out <= 1'b0;
    end else begin
      ctrl               <= next_ctrl;
      len                <= next_len;
      uio                <= next_uio;
      wb_dat_out         <= next_wb_dat;
      wb_ack_out         <= next_wb_ack;
      config_data_out    <= next_data_out;
      config_data_oe_out <= next_data_oe;
    end
  end

endmodule

// file: verilog/pbcl_pkg.sv
package pbcl_pkg;

  typedef enum logic [2:0] {
    PBCL_ST_RESET     = 3'h0,
    PBCL_ST_WAIT_STAT = 3'h1,
    PBCL_ST_LOAD      = 3'h3,
    PBCL_ST_WAIT_DONE = 3'h2,
    PBCL_ST_INIT      = 3'h6,
    PBCL_ST_USER      = 3'h7,
    PBCL_ST_ERROR     = 3'h5
  } pbcl_state_t;

  typedef enum logic [1:0] {
    PBCL_SU_IDLE  = 2'h0,
    PBCL_SU_DELAY = 2'h1,
    PBCL_SU_COUNT = 2'h3,
    PBCL_SU_DONE  = 2'h2
  } pbcl_su_state_t;

endpackage

// file: verilog/pbcl_regs.svh
`ifndef PBCL_REGS_SVH
`define PBCL_REGS_SVH

// Register byte offsets on the Wishbone slave.
`define PBCL_ADR_CTRL          4'h0
`define PBCL_ADR_LEN           4'h4
`define PBCL_ADR_STAT          4'h8
`define PBCL_ADR_UIO           4'hC

// Control register fields.
`define PBCL_CTRL_QUAD         0
`define PBCL_CTRL_USERCLK      1
`define PBCL_CTRL_AUTORST      2
`define PBCL_CTRL_USERIO       3
`define PBCL_CTRL_W            4
`define PBCL_CTRL_RST          4'h0

// Stream length register.
`define PBCL_LEN_W             16
`define PBCL_LEN_RST           16'h0100

// Status register fields.
`define PBCL_STAT_STATE_LSB    16
`define PBCL_STAT_STATUS_LINE  19
`define PBCL_STAT_LOAD_LINE    20
`define PBCL_STAT_INIT_DRIVE   21
`define PBCL_STAT_ERROR        22
`define PBCL_STAT_CHAIN_OUT    23

// User data register reset value.
`define PBCL_UIO_RST           8'h00

// Stream layout: header byte first, option byte second.
`define PBCL_SYNC_BYTE         8'hA5
`define PBCL_OPT_INIT_BIT      0

// Timing figures.
`define PBCL_CLK_PERIOD_NS     10
`define PBCL_CONFIGURATION_CLOCK_MAX_PERIOD_NS 10
`define PBCL_CD2CU_NS          (4 * `PBCL_CONFIGURATION_CLOCK_MAX_PERIOD_NS)
`define PBCL_CD2CU_CYC \
  ((`PBCL_CD2CU_NS + `PBCL_CLK_PERIOD_NS - 1) / `PBCL_CLK_PERIOD_NS)
`define PBCL_INIT_US           20
`define PBCL_INIT_CYC \
  ((`PBCL_INIT_US * 1000 + `PBCL_CLK_PERIOD_NS - 1) / `PBCL_CLK_PERIOD_NS)
`define PBCL_ERR_TIMEOUT_US    100
`define PBCL_ERR_TIMEOUT_CYC \
  ((`PBCL_ERR_TIMEOUT_US * 1000) / `PBCL_CLK_PERIOD_NS)
`define PBCL_USER_CLK_CYCLES   299
`define PBCL_QUAD_PHASES       4

`endif

// file: verilog/pbcl_startup.sv
`timescale 1ns/1ps
`include "pbcl_regs.svh"
module pbcl_startup (
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic run_in,
  input  wire logic use_user_clk_in,
  input  wire logic user_clk_rise_in,
  output logic      done_out
);

  localparam logic [11:0] DELAY_CYC = 12'(`PBCL_CD2CU_CYC);
  localparam logic [11:0] USER_CYC  = 12'(`PBCL_USER_CLK_CYCLES);
  localparam logic [11:0] OSC_CYC   = 12'(`PBCL_INIT_CYC);

  pbcl_pkg::pbcl_su_state_t state;
  pbcl_pkg::pbcl_su_state_t next_state;
  logic [11:0]              cnt;
  logic [11:0]              next_cnt;
  logic                     next_done;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_done  = done_out;
    case (state)
      pbcl_pkg::PBCL_SU_IDLE: begin
        next_done = 1'b0;
        next_cnt  = 12'h000;
        if (run_in) begin
          next_state = use_user_clk_in ? pbcl_pkg::PBCL_SU_DELAY
                                       : pbcl_pkg::PBCL_SU_COUNT;
        end
      end
      pbcl_pkg::PBCL_SU_DELAY: begin
        // The user clock is ignored until the post-load delay runs out.
        next_cnt = cnt + 12'h001;
        if (cnt == DELAY_CYC - 12'h001) begin
          next_cnt   = 12'h000;
          next_state = pbcl_pkg::PBCL_SU_COUNT;
        end
      end
      pbcl_pkg::PBCL_SU_COUNT: begin
        if (use_user_clk_in) begin
          if (user_clk_rise_in) begin
            next_cnt = cnt + 12'h001;
            if (cnt == USER_CYC - 12'h001) begin
              next_state = pbcl_pkg::PBCL_SU_DONE;
            end
          end
        end else begin
          next_cnt = cnt + 12'h001;
          if (cnt == OSC_CYC - 12'h001) begin
            next_state = pbcl_pkg::PBCL_SU_DONE;
          end
        end
      end
      pbcl_pkg::PBCL_SU_DONE: begin
        next_done = 1'b1;
      end
      default: begin
        next_state = pbcl_pkg::PBCL_SU_IDLE;
      end
    endcase
    if (!run_in) begin
      next_state = pbcl_pkg::PBCL_SU_IDLE;
      next_done  = 1'b0;
      next_cnt   = 12'h000;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state    <= pbcl_pkg::PBCL_SU_IDLE;
      cnt      <= 12'h000;
      done_out <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      done_out <= next_done;
    end
  end

endmodule

// file: verilog/pbcl_sync.sv
`timescale 1ns/1ps
module pbcl_sync #(
  parameter int WIDTH = 13
) (
  input  wire logic             clk_sys_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  // Only the second stage may be looked at, so metastability stays here.
  always_comb begin
    next_meta = async_in;
    next_sync = meta;
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync;
    end
  end

endmodule
